// file: hw/lsdc_front.sv
// Segment-mode data capture, line latch and cascade enable of a 96-output LCD driver.
`timescale 1ns/1ps
`default_nettype none
module lsdc_front
  import lsdc_pkg::*;
#(
  parameter int unsigned OUTPUTS = lsdc_pkg::LSDC_OUTPUTS
) (
  input  wire logic                    clk_i,
  input  wire logic                    rst_n_i,
  input  wire lsdc_pkg::lsdc_cfg_type  cfg_i,
  input  wire logic                    data_capture_clock_i,
  input  wire logic                    line_latch_pulse_i,
  input  wire logic                    display_blank_n_i,
  input  wire logic                    frame_inversion_i,
  input  wire logic [3:0]              display_data_inputs_i,
  input  wire logic                    cascade_enable_a_i,
  output logic                         cascade_enable_a_o,
  output logic                         cascade_enable_a_oe_o,
  input  wire logic                    cascade_enable_b_i,
  output logic                         cascade_enable_b_o,
  output logic                         cascade_enable_b_oe_o,
  output logic                         selected_o,
  output logic [2*OUTPUTS-1:0]         lcd_drive_outputs_o
);

  import lsdc_pkg::*;

  // ****************************************************************
  // Pin synchronisation
  // ****************************************************************
  lsdc_pins_type pins_raw;
  lsdc_pins_type pins;
  lsdc_pins_type pins_rst;

  // The enable input comes from the pin that the direction bit makes an input.
  always_comb
  begin
    pins_raw.capture_clk = data_capture_clock_i;
    pins_raw.latch_pulse = line_latch_pulse_i;
    pins_raw.blank_n     = display_blank_n_i;
    pins_raw.frame_inv   = frame_inversion_i;
    pins_raw.enable_in   = cfg_i.cascade_dir ? cascade_enable_a_i
                                             : cascade_enable_b_i;
    pins_raw.data        = display_data_inputs_i;
    pins_rst             = '0;
    pins_rst.blank_n     = 1'b1;
    pins_rst.enable_in   = 1'b1;
  end

  lsdc_sync2 #(
    .WIDTH($bits(lsdc_pins_type))
  ) lsdc_sync2_inst (
    .clk_i      (clk_i),
    .rst_n_i    (rst_n_i),
    .async_i    (pins_raw),
    .reset_val_i(pins_rst),
    .sync_o     (pins)
  );

  // ****************************************************************
  // Edge history of synchronised strobes
  // ****************************************************************
  logic ck_prev_q;
  logic lp_prev_q;
  logic bl_prev_q;
  logic ck_rise;
  logic ck_fall;
  logic lp_fall;
  logic bl_release;

  // Edges of the strobes are taken from the synchronised copies only.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      ck_prev_q <= 1'b0;
      lp_prev_q <= 1'b0;
      bl_prev_q <= 1'b1;
    end
    else
    begin
      ck_prev_q <= pins.capture_clk;
      lp_prev_q <= pins.latch_pulse;
      bl_prev_q <= pins.blank_n;
    end
  end

  assign ck_rise    = pins.capture_clk & ~ck_prev_q;
  assign ck_fall    = ~pins.capture_clk & ck_prev_q;
  assign lp_fall    = ~pins.latch_pulse & lp_prev_q;
  assign bl_release = pins.blank_n & ~bl_prev_q;

  // ****************************************************************
  // Selection, bit counting and data latch
  // ****************************************************************
  logic [OUTPUTS-1:0] data_latch_q;
  logic [OUTPUTS-1:0] data_latch_d;
  logic [6:0]         count_q;
  logic [6:0]         count_d;
  logic               armed_q;
  logic               armed_d;
  logic               selected_q;
  logic               selected_d;
  logic               done_q;
  logic               done_d;
  logic [6:0]         limit;
  logic [6:0]         step;
  logic [6:0]         count_next;

  assign limit      = lsdc_limit(cfg_i.bit_limit_sel);
  assign step       = cfg_i.serial_mode ? LSDC_SER_STEP : LSDC_PAR_STEP;
  assign count_next = count_q + step;

  // The data latch is written regardless of blanking, as the panel only hides it.
  always_comb
  begin
    data_latch_d = data_latch_q;
    count_d      = count_q;
    armed_d      = armed_q;
    selected_d   = selected_q;
    done_d       = 1'b0;
    if (lp_fall)
    begin
      armed_d = 1'b1;
      count_d = LSDC_CNT_RESET;
    end
    else if (armed_q && !selected_q && !pins.enable_in)
    begin
      selected_d = 1'b1;
      armed_d    = 1'b0;
    end
    if (selected_q && ck_rise && !lp_fall)
    begin
      // Shift away from the input end so the first bit ends at the far end.
      if (cfg_i.serial_mode)
      begin
        data_latch_d = cfg_i.cascade_dir
          ? {data_latch_q[OUTPUTS-2:0], pins.data[0]}
          : {pins.data[0], data_latch_q[OUTPUTS-1:1]};
      end
      else
      begin
        data_latch_d = cfg_i.cascade_dir
          ? {data_latch_q[OUTPUTS-5:0], pins.data}
          : {pins.data, data_latch_q[OUTPUTS-1:4]};
      end
      count_d = count_next;
      if (count_next >= limit)
      begin
        selected_d = 1'b0;
        done_d     = 1'b1;
      end
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      data_latch_q <= '0;
      count_q      <= LSDC_CNT_RESET;
      armed_q      <= 1'b0;
      selected_q   <= 1'b0;
      done_q       <= 1'b0;
    end
    else
    begin
      data_latch_q <= data_latch_d;
      count_q      <= count_d;
      armed_q      <= armed_d;
      selected_q   <= selected_d;
      done_q       <= done_d;
    end
  end

  // ****************************************************************
  // Cascade enable output
  // ****************************************************************
  logic en_low_q;
  logic en_low_d;
  logic pend_q;
  logic pend_d;

  // Low from the falling capture edge after the last bit to the next one.
  always_comb
  begin
    en_low_d = en_low_q;
    pend_d   = pend_q | done_q;
    if (ck_fall)
    begin
      en_low_d = pend_q | done_q;
      pend_d   = 1'b0;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      en_low_q <= 1'b0;
      pend_q   <= 1'b0;
    end
    else
    begin
      en_low_q <= en_low_d;
      pend_q   <= pend_d;
    end
  end

  // Direction bit decides which pin drives; the other stays an input.
  always_comb
  begin
    cascade_enable_a_o    = ~en_low_q;
    cascade_enable_b_o    = ~en_low_q;
    cascade_enable_a_oe_o = ~cfg_i.cascade_dir;
    cascade_enable_b_oe_o = cfg_i.cascade_dir;
  end

  assign selected_o = selected_q;

  // ****************************************************************
  // Line latch and output levels
  // ****************************************************************
  logic [OUTPUTS-1:0]   line_latch_q;
  logic [OUTPUTS-1:0]   line_latch_d;
  logic                 nonsel_q;
  logic                 nonsel_d;
  logic [2*OUTPUTS-1:0] drive_q;
  logic [2*OUTPUTS-1:0] drive_d;

  // Blanking clears the line latch and holds non-select until a latch pulse.
  always_comb
  begin
    line_latch_d = line_latch_q;
    nonsel_d     = nonsel_q;
    if (!pins.blank_n)
    begin
      line_latch_d = '0;
      nonsel_d     = 1'b1;
    end
    else if (lp_fall)
    begin
      line_latch_d = data_latch_q;
      nonsel_d     = 1'b0;
    end
  end

  // Select level follows data xor frame; non-select uses bias two or three.
  always_comb
  begin
    lsdc_level_type lvl;
    lvl     = LSDC_LVL_GND;
    drive_d = '0;
    for (int i = 0; i < OUTPUTS; i++)
    begin
      if (!pins.blank_n)
      begin
        lvl = LSDC_LVL_GND;
      end
      else if (line_latch_d[i] && !nonsel_d)
      begin
        lvl = pins.frame_inv ? LSDC_LVL_GND : LSDC_LVL_BIAS0;
      end
      else
      begin
        lvl = pins.frame_inv ? LSDC_LVL_BIAS3 : LSDC_LVL_BIAS2;
      end
      drive_d[2*i +: 2] = lvl;
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      line_latch_q <= '0;
      nonsel_q     <= 1'b1;
      drive_q      <= '0;
    end
    else
    begin
      line_latch_q <= line_latch_d;
      nonsel_q     <= nonsel_d;
      drive_q      <= drive_d;
    end
  end

  assign lcd_drive_outputs_o = drive_q;

  // ****************************************************************
  // Assertions
  // ****************************************************************
  a_blank_forces_gnd: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!pins.blank_n) |=> (drive_q == '0))
    else $error("Outputs not at ground during blanking.");

  a_blank_clears_line: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (!pins.blank_n) |=> (line_latch_q == '0))
    else $error("Line latch not cleared during blanking.");

  a_latch_on_fall: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (lp_fall && pins.blank_n) |=> (line_latch_q == $past(data_latch_q)))
    else $error("Line latch did not load on latch pulse fall.");

  a_release_nonsel: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (bl_release && !lp_fall) |=> nonsel_q)
    else $error("Non-select not held after blank release.");

  a_enable_low_one: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    $fell(en_low_q) |-> $past(ck_fall))
    else $error("Enable output low did not end on a capture fall.");

  a_count_step: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (selected_q && ck_rise && !lp_fall) |=>
      (count_q == $past(count_q) + ($past(cfg_i.serial_mode) ? 7'h01 : 7'h04)))
    else $error("Bit count step wrong.");

  a_stop_at_limit: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (selected_q && count_q >= limit) |-> 1'b0)
    else $error("Still selected past bit limit.");

  a_select_on_enable: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    (armed_q && !selected_q && !pins.enable_in && !lp_fall) |=> selected_q)
    else $error("Not selected on low enable input.");

  a_dir_pins: assert property (
    @(posedge clk_i) disable iff (!rst_n_i)
    cascade_enable_a_oe_o != cascade_enable_b_oe_o)
    else $error("Both or neither enable pins driven.");

endmodule
`default_nettype wire

// file: hw/lsdc_pkg.sv
// Package with constants and carrier types of the LCD segment data input front end.
package lsdc_pkg;

  // ****************************************************************
  // Geometry and counts
  // ****************************************************************
  localparam int unsigned LSDC_OUTPUTS     = 96;
  localparam int unsigned LSDC_BUS_BITS    = 4;
  localparam int unsigned LSDC_CNT_W       = 7;
  localparam logic [6:0]  LSDC_CNT_RESET   = 7'h00;
  localparam logic [6:0]  LSDC_PAR_STEP    = 7'h04;
  localparam logic [6:0]  LSDC_SER_STEP    = 7'h01;
  localparam logic [2:0]  LSDC_LIMIT_RESET = 3'h6;
  localparam int unsigned LSDC_LIMIT_STEP  = 16;

  // ****************************************************************
  // Drive level codes per output
  // ****************************************************************
  typedef enum logic [1:0] {
    LSDC_LVL_GND   = 2'h0,
    LSDC_LVL_BIAS0 = 2'h1,
    LSDC_LVL_BIAS2 = 2'h2,
    LSDC_LVL_BIAS3 = 2'h3
  } lsdc_level_type;

  // Configuration bits that would come from the command interface.
  typedef struct packed {
    logic       cascade_dir;
    logic       serial_mode;
    logic [2:0] bit_limit_sel;
  } lsdc_cfg_type;

  // Synchronised link pins.
  typedef struct packed {
    logic       capture_clk;
    logic       latch_pulse;
    logic       blank_n;
    logic       frame_inv;
    logic       enable_in;
    logic [3:0] data;
  } lsdc_pins_type;

  // Bit count reached for a limit selector code; 0 reads as 96.
  function automatic logic [6:0] lsdc_limit(input logic [2:0] sel);
    logic [6:0] lim;
    lim = 7'(LSDC_OUTPUTS);
    if (sel != 3'h0 && sel < LSDC_LIMIT_RESET)
    begin
      lim = 7'(LSDC_LIMIT_STEP * sel);
    end
    return lim;
  endfunction

endpackage

// file: hw/lsdc_sync2.sv
// Two-flop synchroniser for a vector of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module lsdc_sync2 #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic [WIDTH-1:0] async_i,
  input  wire logic [WIDTH-1:0] reset_val_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] sync_q;
  logic [WIDTH-1:0] sync_d;
  logic             seeded_q;

  // The first stage feeds only the second; the reset value seeds after release.
  always_comb
  begin
    meta_d = async_i;
    sync_d = seeded_q ? meta_q : reset_val_i;
  end

  // Both stages clear to zero so no port value enters the reset branch.
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      meta_q   <= '0;
      sync_q   <= '0;
      seeded_q <= 1'b0;
    end
    else
    begin
      meta_q   <= meta_d;
      sync_q   <= sync_d;
      seeded_q <= 1'b1;
    end
  end

  // The seed value shows until the second edge after release, so no strobe sees a false edge.
  assign sync_o = seeded_q ? sync_q : reset_val_i;

endmodule
`default_nettype wire

// file: testbench/lsdc_ctl_model.sv
// Behavioural model of the timing controller that feeds the segment front end.
`timescale 1ns/1ps
`default_nettype none
module lsdc_ctl_model (
  input  wire logic       clk_i,
  output logic            cap_o,
  output logic            latch_o,
  output logic            en_o,
  output logic [3:0]      data_o
);
  // The capture clock stands low between lines and the chain enable idles high.
  initial
  begin
    cap_o = 1'b0;
    latch_o = 1'b0;
    en_o = 1'b1;
    data_o = 4'h0;
  end

  // Every pin level is held four clocks, twice the two the synchroniser needs.
  task automatic half();
    repeat (4) @(negedge clk_i);
  endtask

  // One full capture clock period; the rise is the sampling edge.
  task automatic tick();
    half();
    cap_o = 1'b1;
    half();
    cap_o = 1'b0;
  endtask

  // A latch pulse whose falling edge loads the line latch.
  task automatic pulse_latch();
    latch_o = 1'b1;
    half();
    latch_o = 1'b0;
    half();
  endtask

  // Drives the input side of the chain enable, as the neighbouring chip does.
  task automatic set_en(input logic lvl);
    en_o = lvl;
    half();
    half();
  endtask

  // Sends count units from unit first on; data is stable across each rise.
  task automatic send(input logic [95:0] bits, input int first, input int count,
                      input logic ser);
    for (int i = first; i < first + count; i++)
    begin
      if (ser)
        data_o = {3'h0, bits[i]};
      else
        data_o = bits[4*i +: 4];
      tick();
    end
    // Stale bits would hide a late capture, so the lines show their inverse.
    data_o = ser ? {3'h0, ~data_o[0]} : ~data_o;
    // One clock passes so a following call never drives the lines twice in one step.
    @(negedge clk_i);
  endtask
endmodule
`default_nettype wire

// file: testbench/test_lsdc_front.sv
// Self-checking testbench of the segment data input front end.
`timescale 1ns/1ps
`default_nettype none
module test_lsdc_front;
  import lsdc_pkg::*;
  logic         clk;
  logic         rst_n;
  logic         blank_n;
  logic         frame;
  logic         cap;
  logic         lp;
  logic         ctl_en;
  logic [3:0]   data;
  logic         pin_a;
  logic         pin_b;
  logic         a_o;
  logic         a_oe;
  logic         b_o;
  logic         b_oe;
  logic         sel_o;
  logic [191:0] drv;
  lsdc_cfg_type cfg;
  logic [95:0]  pat;
  logic [95:0]  par;
  logic [95:0]  rev;
  logic         en_out;
  int           n_errors;
  int           compares;

  // ****************************************************************
  // Clock, pin resolution and instances
  // ****************************************************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Each enable wire carries the driver that has it enabled, else the neighbour.
  assign pin_a = a_oe ? a_o : ctl_en;
  assign pin_b = b_oe ? b_o : ctl_en;
  assign en_out = cfg.cascade_dir ? b_o : a_o;

  lsdc_ctl_model lsdc_ctl_model_inst (
    .clk_i   (clk),
    .cap_o   (cap),
    .latch_o (lp),
    .en_o    (ctl_en),
    .data_o  (data)
  );

  lsdc_front lsdc_front_inst (
    .clk_i                 (clk),
    .rst_n_i               (rst_n),
    .cfg_i                 (cfg),
    .data_capture_clock_i  (cap),
    .line_latch_pulse_i    (lp),
    .display_blank_n_i     (blank_n),
    .frame_inversion_i     (frame),
    .display_data_inputs_i (data),
    .cascade_enable_a_i    (pin_a),
    .cascade_enable_a_o    (a_o),
    .cascade_enable_a_oe_o (a_oe),
    .cascade_enable_b_i    (pin_b),
    .cascade_enable_b_o    (b_o),
    .cascade_enable_b_oe_o (b_oe),
    .selected_o            (sel_o),
    .lcd_drive_outputs_o   (drv)
  );

  // ****************************************************************
  // Helpers
  // ****************************************************************
  task automatic finish_test();
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  task automatic check(input string what, input logic [191:0] seen, input logic [191:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("Error %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wait_n(input int n);
    repeat (n) @(negedge clk);
  endtask

  // Expected drive word; gnd forces every output to ground.
  function automatic logic [191:0] exp_drv(input logic [95:0] b, input logic fr,
                                           input logic gnd);
    logic [191:0] r;
    for (int i = 0; i < 96; i++)
      r[2*i +: 2] = gnd ? LSDC_LVL_GND : b[i] ? (fr ? LSDC_LVL_GND : LSDC_LVL_BIAS0)
                                       : (fr ? LSDC_LVL_BIAS3 : LSDC_LVL_BIAS2);
    return r;
  endfunction

  // One selected line: the count must end exactly at the last unit.
  task automatic run_line(input logic [95:0] bits, input int units, input logic ser);
    lsdc_ctl_model_inst.pulse_latch();
    lsdc_ctl_model_inst.set_en(1'b0);
    check("selected", 192'(sel_o), 192'(1'b1));
    lsdc_ctl_model_inst.send(bits, 0, units - 1, ser);
    check("selected", 192'(sel_o), 192'(1'b1));
    lsdc_ctl_model_inst.send(bits, units - 1, 1, ser);
    wait_n(3);
    check("selected", 192'(sel_o), 192'(1'b0));
    wait_n(4);
    check("enable_out", 192'(en_out), 192'(1'b0));
    lsdc_ctl_model_inst.tick();
    wait_n(7);
    check("enable_out", 192'(en_out), 192'(1'b1));
    lsdc_ctl_model_inst.set_en(1'b1);
  endtask

  // ****************************************************************
  // Test sequence
  // ****************************************************************
  initial
  begin
    rst_n = 1'b0;
    blank_n = 1'b1;
    frame = 1'b0;
    cfg = '{1'b0, 1'b0, 3'h0};
    n_errors = 0;
    compares = 0;
    pat = 96'h8C3E_0F15_A6D2_47B9_E013_5C7A;
    for (int i = 0; i < 24; i++)
    begin
      par[4*i +: 4] = (i % 3 == 0) ? 4'hF : 4'h0;
      rev[4*(23-i) +: 4] = par[4*i +: 4];
    end
    repeat (2) @(negedge clk);
    rst_n = 1'b1;
    wait_n(3);
    check("drive", drv, exp_drv(96'h0, 1'b0, 1'b0));
    check("enable_oe", 192'({a_oe, b_oe}), 192'(2'b10));
    check("enable_out", 192'(en_out), 192'(1'b1));
    // Serial line, data entering from the top end.
    cfg = '{1'b0, 1'b1, 3'h6};
    run_line(pat, 96, 1'b1);
    lsdc_ctl_model_inst.pulse_latch();
    wait_n(2);
    check("drive", drv, exp_drv(pat, 1'b0, 1'b0));
    frame = 1'b1;
    wait_n(6);
    check("drive", drv, exp_drv(pat, 1'b1, 1'b0));
    // Blanking while a parallel line is taken in the other direction.
    blank_n = 1'b0;
    wait_n(6);
    check("drive", drv, exp_drv(96'h0, 1'b1, 1'b1));
    cfg = '{1'b1, 1'b0, 3'h0};
    wait_n(1);
    check("enable_oe", 192'({a_oe, b_oe}), 192'(2'b01));
    run_line(par, 24, 1'b0);
    blank_n = 1'b1;
    wait_n(6);
    check("drive", drv, exp_drv(96'h0, 1'b1, 1'b0));
    lsdc_ctl_model_inst.pulse_latch();
    wait_n(2);
    check("drive", drv, exp_drv(rev, 1'b1, 1'b0));
    // Every bit limit code; codes 0, 6 and 7 all mean the full line.
    for (int s = 0; s < 8; s++)
    begin
      cfg = '{1'b0, 1'b0, 3'(s)};
      run_line(par, (s == 0 || s > 5) ? 24 : 4 * s, 1'b0);
    end
    // Serial line entering at bit zero: the first bit must end at the top.
    for (int i = 0; i < 96; i++)
      rev[95 - i] = pat[i];
    cfg = '{1'b1, 1'b1, 3'h0};
    run_line(pat, 96, 1'b1);
    lsdc_ctl_model_inst.pulse_latch();
    wait_n(2);
    check("drive", drv, exp_drv(rev, 1'b1, 1'b0));
    finish_test();
  end

  // Cuts a hang short, well beyond the few thousand clocks the tests need.
  initial
  begin
    repeat (20000) @(posedge clk);
    n_errors++;
    finish_test();
  end
endmodule
`default_nettype wire
